//--- fbt_timer.sv
// free-running base timer with channel request routing, apb slave
`timescale 1ns/1ps
`include "fbt_consts.svh"
module fbt_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        phase_a_input,
    input  wire logic        phase_b_input,
    input  wire logic        external_reset_pin_n,
    input  wire logic [7:0]  chan_event,
    output logic             timer_irq,
    output logic             shared_irq0,
    output logic             shared_irq1,
    output logic             ch0_match
);
    import fbt_pkg::*;

    fbt_state_s st;
    fbt_state_s next_st;
    fbt_mode_e  mode;
    fbt_src_e   src;
    logic       tick;
    logic       run;
    logic       wr;
    logic       rd_setup;
    logic       mapped;
    logic       wr_cnt;
    logic       ext_hit;
    logic       match_hit;
    logic       ch0_hit;
    logic       up_step;
    logic       ovf;
    logic       phase_evt;
    logic       en0;
    logic       en1;

    // ================================================================
    // address match, shared by the counter and flag write decode
    function automatic logic fbt_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ================================================================
    // decode of control fields
    assign run     = st.ctrl1[`FBT_C1_RUN_BIT];
    assign mode    = fbt_mode_e'(st.ctrl1[`FBT_C1_MODE_MSB:`FBT_C1_MODE_LSB]);
    // two-phase mode forces the phase pins as the count source
    assign src     = (mode == FBT_PHASE) ? FBT_SRC_PHASE
                   : fbt_src_e'(st.ctrl0[`FBT_C0_SRC_MSB:`FBT_C0_SRC_LSB]);
    assign ext_hit = st.ctrl1[`FBT_C1_EXTRST_BIT] & ~external_reset_pin_n;
    // a reset register match only counts with its enable set
    assign match_hit = st.ctrl0[`FBT_C0_RESET_REGISTER_MATCH_ENABLE_BIT] & (st.cnt == st.match_rst);
    assign ch0_hit   = st.ctrl1[`FBT_C1_CH0RST_BIT] & (st.cnt == st.ch0_cmp);

    // ================================================================
    // apb strobes: write lands at the access edge with pready high
    assign wr       = psel & penable & st.pready & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wr_cnt   = wr & fbt_hit(paddr, `FBT_OFF_COUNT);

    always_comb begin
        case (paddr)
            `FBT_OFF_CTRL0, `FBT_OFF_CTRL1, `FBT_OFF_COUNT, `FBT_OFF_DIV,
            `FBT_OFF_MATCH, `FBT_OFF_CH0CMP, `FBT_OFF_CHREQ, `FBT_OFF_MASK0,
            `FBT_OFF_MASK1, `FBT_OFF_TIMER_IRQ, `FBT_OFF_SHARED: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ================================================================
    // phase pins: any edge is an event, direction from the pin order
    assign phase_evt = (phase_a_input ^ st.ph_a) | (phase_b_input ^ st.ph_b);

    // ================================================================
    // up steps are where overflow out of bit 14 or 15 can occur
    always_comb begin
        case (mode)
            FBT_UP:    up_step = 1'b1;
            FBT_UPDN:  up_step = ~st.count_down;
            FBT_PHASE: up_step = st.ph_up;
            default:   up_step = 1'b1;
        endcase
    end
    assign ovf = up_step & (st.ctrl0[`FBT_C0_OVSEL_BIT] ? (st.cnt == `FBT_CNT_MAX)
                                                        : (st.cnt[14:0] == `FBT_HALF_MAX));

    // ================================================================
    // shared interrupt causes, gated by the enable masks
    assign en0 = |(st.chan_req & st.mask0);
    assign en1 = |(st.chan_req & st.mask1);

    // ================================================================
    // count source prescaler
    fbt_prescaler fbt_prescaler_inst (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (~run),
        .src       (src),
        .phase_evt (phase_evt),
        .ratio     (st.div),
        .tick      (tick)
    );

    // ================================================================
    // next state: bus answer, registers, counter and request flags
    always_comb begin
        next_st           = st;
        next_st.pready    = psel & ~penable;
        next_st.pslverr   = psel & ~penable & ~mapped;
        next_st.prdata    = `FBT_RD_ZERO;
        next_st.ch0_match = 1'b0;
        next_st.ph_a      = phase_a_input;
        next_st.ph_b      = phase_b_input;
        if (phase_evt) begin
            next_st.ph_up = phase_a_input ^ st.ph_b;
        end

        // read data is captured in the setup cycle, stable in access
        if (rd_setup) begin
            case (paddr)
                `FBT_OFF_CTRL0:     next_st.prdata = {24'h000000, st.ctrl0};
                `FBT_OFF_CTRL1:     next_st.prdata = {24'h000000, st.ctrl1};
                `FBT_OFF_COUNT:     next_st.prdata = {16'h0000, st.cnt};
                `FBT_OFF_DIV:       next_st.prdata = {24'h000000, st.div};
                `FBT_OFF_MATCH:     next_st.prdata = {16'h0000, st.match_rst};
                `FBT_OFF_CH0CMP:    next_st.prdata = {16'h0000, st.ch0_cmp};
                `FBT_OFF_CHREQ:     next_st.prdata = {24'h000000, st.chan_req};
                `FBT_OFF_MASK0:     next_st.prdata = {24'h000000, st.mask0};
                `FBT_OFF_MASK1:     next_st.prdata = {24'h000000, st.mask1};
                `FBT_OFF_TIMER_IRQ: next_st.prdata = {31'h00000000, st.timer_ir};
                `FBT_OFF_SHARED:    next_st.prdata = {30'h00000000, st.irq1_ir, st.irq0_ir};
                default:            next_st.prdata = `FBT_RD_ZERO;
            endcase
        end

        // plain register writes
        if (wr) begin
            case (paddr)
                `FBT_OFF_CTRL0:  next_st.ctrl0     = pwdata[7:0];
                `FBT_OFF_CTRL1:  next_st.ctrl1     = pwdata[7:0];
                `FBT_OFF_DIV:    next_st.div       = pwdata[7:0];
                `FBT_OFF_MATCH:  next_st.match_rst = pwdata[15:0];
                `FBT_OFF_CH0CMP: next_st.ch0_cmp   = pwdata[15:0];
                `FBT_OFF_MASK0:  next_st.mask0     = pwdata[7:0];
                `FBT_OFF_MASK1:  next_st.mask1     = pwdata[7:0];
                default:         next_st.ctrl0     = st.ctrl0;
            endcase
        end

        // flags: writing zero clears, writing one leaves them alone
        if (wr && fbt_hit(paddr, `FBT_OFF_CHREQ)) begin
            next_st.chan_req = st.chan_req & pwdata[7:0];
        end
        if (wr && fbt_hit(paddr, `FBT_OFF_TIMER_IRQ) && !pwdata[`FBT_IR_BIT]) begin
            next_st.timer_ir = 1'b0;
        end
        if (wr && fbt_hit(paddr, `FBT_OFF_SHARED)) begin
            next_st.irq0_ir = st.irq0_ir & pwdata[`FBT_SH0_BIT];
            next_st.irq1_ir = st.irq1_ir & pwdata[`FBT_SH1_BIT];
        end

        // counter: stop, pin reset, load, match resets, then counting
        if (!run) begin
            // held in reset: the counter sits at zero, writes are dropped
            next_st.cnt        = `FBT_CNT_ZERO;
            next_st.count_down = 1'b0;
        end else if (ext_hit) begin
            next_st.cnt        = `FBT_CNT_ZERO;
            next_st.count_down = 1'b0;
        end else if (wr_cnt) begin
            next_st.cnt = pwdata[15:0];
        end else if (tick) begin
            // compare output keeps working whichever match resets the timer
            next_st.ch0_match = (st.cnt == st.ch0_cmp);
            if (match_hit) begin
                next_st.cnt        = `FBT_CNT_ZERO;
                next_st.count_down = 1'b0;
                next_st.timer_ir   = 1'b1;
            end else if (ch0_hit) begin
                next_st.cnt        = `FBT_CNT_ZERO;
                next_st.count_down = 1'b0;
            end else begin
                if (ovf) begin
                    next_st.timer_ir = 1'b1;
                end
                case (mode)
                    FBT_UP: begin
                        next_st.cnt = st.cnt + `FBT_CNT_ONE;
                    end
                    FBT_UPDN: begin
                        // turn around at the ends instead of wrapping
                        if (!st.count_down && st.cnt == `FBT_CNT_MAX) begin
                            next_st.cnt        = `FBT_CNT_TURN;
                            next_st.count_down = 1'b1;
                        end else if (st.count_down && st.cnt == `FBT_CNT_ZERO) begin
                            next_st.cnt        = `FBT_CNT_ONE;
                            next_st.count_down = 1'b0;
                        end else if (st.count_down) begin
                            next_st.cnt = st.cnt - `FBT_CNT_ONE;
                        end else begin
                            next_st.cnt = st.cnt + `FBT_CNT_ONE;
                        end
                    end
                    FBT_PHASE: begin
                        next_st.cnt = st.ph_up ? st.cnt + `FBT_CNT_ONE
                                               : st.cnt - `FBT_CNT_ONE;
                    end
                    default: begin
                        next_st.cnt = st.cnt + `FBT_CNT_ONE;
                    end
                endcase
            end
        end

        // channel causes set after any clear, so a set is never lost
        next_st.chan_req  = next_st.chan_req | chan_event;
        // only a fresh rise of the masked causes raises a shared request
        next_st.req0_prev = en0;
        next_st.req1_prev = en1;
        if (en0 && !st.req0_prev) begin
            next_st.irq0_ir = 1'b1;
        end
        if (en1 && !st.req1_prev) begin
            next_st.irq1_ir = 1'b1;
        end
    end

    // ================================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ================================================================
    // outputs straight from the state flops
    assign prdata      = st.prdata;
    assign pready      = st.pready;
    assign pslverr     = st.pslverr;
    assign timer_irq   = st.timer_ir;
    assign shared_irq0 = st.irq0_ir;
    assign shared_irq1 = st.irq1_ir;
    assign ch0_match   = st.ch0_match;

    // ================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_running_tick;
        run && !ext_hit && !wr_cnt && tick;
    endsequence

    sequence seq_fresh_cause0;
        en0 && !st.req0_prev;
    endsequence

    AST_STOP_HOLDS: assert property (!run |=> st.cnt == `FBT_CNT_ZERO)
        else $error("stopped timer did not hold zero");

    AST_WRITE_LOADS: assert property (run && !ext_hit && wr_cnt |=> st.cnt == $past(pwdata[15:0]))
        else $error("counter write while running was not loaded");

    AST_WRITE_DROPPED: assert property (!run && wr_cnt |=> st.cnt == `FBT_CNT_ZERO)
        else $error("counter write while stopped took effect");

    AST_MATCH_RESET: assert property (seq_running_tick ##0 match_hit
                                      |=> st.cnt == `FBT_CNT_ZERO && st.timer_ir)
        else $error("reset register match did not clear and flag");

    AST_CH0_RESET: assert property (seq_running_tick ##0 (!match_hit && ch0_hit)
                                    |=> st.cnt == `FBT_CNT_ZERO)
        else $error("channel 0 match did not clear the counter");

    AST_PIN_RESET: assert property (run && ext_hit |=> st.cnt == `FBT_CNT_ZERO)
        else $error("external pin low did not clear the counter");

    AST_UP_WRAP: assert property (seq_running_tick ##0 (mode == FBT_UP && !match_hit && !ch0_hit
                                  && st.cnt == `FBT_CNT_MAX && st.ctrl0[`FBT_C0_OVSEL_BIT])
                                  |=> st.cnt == `FBT_CNT_ZERO && st.timer_ir)
        else $error("up count did not wrap with overflow request");

    AST_HALF_OVF: assert property (seq_running_tick ##0 (!match_hit && !ch0_hit && up_step
                                   && !st.ctrl0[`FBT_C0_OVSEL_BIT] && st.cnt[14:0] == `FBT_HALF_MAX)
                                   |=> st.timer_ir)
        else $error("bit 14 overflow raised no request");

    AST_UPDN_TURN: assert property (seq_running_tick ##0 (mode == FBT_UPDN && !match_hit && !ch0_hit
                                    && !st.count_down && st.cnt == `FBT_CNT_MAX)
                                    |=> st.cnt == `FBT_CNT_TURN && st.count_down)
        else $error("up/down count did not turn at the top");

    AST_REQ_SET: assert property (|chan_event |=> (st.chan_req & $past(chan_event)) == $past(chan_event))
        else $error("channel event did not set its request bit");

    AST_REQ_STICKY: assert property (!(wr && fbt_hit(paddr, `FBT_OFF_CHREQ))
                                     |=> (st.chan_req & $past(st.chan_req)) == $past(st.chan_req))
        else $error("request bit dropped without a software write");

    AST_SHARED_RAISE: assert property (seq_fresh_cause0 |=> st.irq0_ir)
        else $error("fresh enabled cause did not raise shared 0");

    // a cause that stays enabled must not raise a cleared flag again
    AST_NO_RETRIGGER: assert property (en0 && st.req0_prev && !st.irq0_ir
                                       |=> !st.irq0_ir)
        else $error("pending request raised shared 0 again");
endmodule

//--- fbt_consts.svh
// offsets, field positions, reset values and limits of the base timer
`ifndef FBT_CONSTS_SVH
`define FBT_CONSTS_SVH

// ====================================================================
// register byte offsets on the apb side
`define FBT_OFF_CTRL0     8'h00
`define FBT_OFF_CTRL1     8'h04
`define FBT_OFF_COUNT     8'h08
`define FBT_OFF_DIV       8'h0c
`define FBT_OFF_MATCH     8'h10
`define FBT_OFF_CH0CMP    8'h14
`define FBT_OFF_CHREQ     8'h18
`define FBT_OFF_MASK0     8'h1c
`define FBT_OFF_MASK1     8'h20
`define FBT_OFF_TIMER_IRQ 8'h24
`define FBT_OFF_SHARED    8'h28

// ====================================================================
// field positions
`define FBT_C0_SRC_LSB    0
`define FBT_C0_SRC_MSB    1
`define FBT_C0_RESET_REGISTER_MATCH_ENABLE_BIT   2
`define FBT_C0_OVSEL_BIT  3
`define FBT_C1_RUN_BIT    0
`define FBT_C1_CH0RST_BIT 1
`define FBT_C1_EXTRST_BIT 2
`define FBT_C1_MODE_LSB   4
`define FBT_C1_MODE_MSB   5
`define FBT_IR_BIT        0
`define FBT_SH0_BIT       0
`define FBT_SH1_BIT       1

// ====================================================================
// reset values and counter limits
`define FBT_BYTE_RST      8'h00
`define FBT_CNT_ZERO      16'h0000
`define FBT_CNT_MAX       16'hffff
`define FBT_CNT_TURN      16'hfffe
`define FBT_HALF_MAX      15'h7fff
`define FBT_CNT_ONE       16'h0001
`define FBT_RD_ZERO       32'h0000_0000

`endif

//--- fbt_pkg.sv
// types shared by the base timer and its prescaler
package fbt_pkg;

    // ================================================================
    // counting operations
    typedef enum logic [1:0] {
        FBT_UP    = 2'b00,
        FBT_UPDN  = 2'b01,
        FBT_PHASE = 2'b10,
        FBT_RSV   = 2'b11
    } fbt_mode_e;

    // ================================================================
    // count source selection
    typedef enum logic [1:0] {
        FBT_SRC_F1    = 2'b00,
        FBT_SRC_F2    = 2'b01,
        FBT_SRC_PHASE = 2'b10,
        FBT_SRC_RSV   = 2'b11
    } fbt_src_e;

    // ================================================================
    // prescaler state
    typedef struct packed {
        logic [7:0] cnt;
        logic       half;
        logic       tick;
    } fbt_div_state_s;

    // ================================================================
    // base timer state, registers and bus answer together
    typedef struct packed {
        logic [7:0]  ctrl0;
        logic [7:0]  ctrl1;
        logic [15:0] cnt;
        logic [7:0]  div;
        logic [15:0] match_rst;
        logic [15:0] ch0_cmp;
        logic [7:0]  chan_req;
        logic [7:0]  mask0;
        logic [7:0]  mask1;
        logic        timer_ir;
        logic        irq0_ir;
        logic        irq1_ir;
        logic        req0_prev;
        logic        req1_prev;
        logic        count_down;
        logic        ph_a;
        logic        ph_b;
        logic        ph_up;
        logic        ch0_match;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } fbt_state_s;

endpackage

//--- fbt_prescaler.sv
// count source prescaler: picks a source and divides it by ratio plus one
`timescale 1ns/1ps
`include "fbt_consts.svh"
module fbt_prescaler (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clear,
    input  wire fbt_pkg::fbt_src_e src,
    input  wire logic             phase_evt,
    input  wire logic [7:0]       ratio,
    output logic                  tick
);
    import fbt_pkg::*;

    fbt_div_state_s st;
    fbt_div_state_s next_st;
    logic           base;

    // ================================================================
    // source pick and divide by n+1, ratio zero passes every pulse
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        next_st.half = ~st.half;
        case (src)
            FBT_SRC_F1:    base = 1'b1;
            FBT_SRC_F2:    base = st.half;
            FBT_SRC_PHASE: base = phase_evt;
            default:       base = 1'b1;
        endcase
        if (clear) begin
            // a stopped timer restarts the division from a clean phase
            next_st = '0;
        end else if (base) begin
            if (st.cnt >= ratio) begin
                next_st.cnt  = `FBT_BYTE_RST;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 8'h01;
            end
        end
    end

    // ================================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule

//--- fbt_phase_src.sv
// two-phase pulse source model for the phase pins of the base timer
`timescale 1ns/1ps
module fbt_phase_src (
    input  wire logic pclk,
    output logic      phase_a,
    output logic      phase_b
);
    // pins idle low; push-pull, so the last level simply stays
    initial begin
        phase_a = 1'b0;
        phase_b = 1'b0;
    end
    // quadrature steps, a leads b when fwd; gap sets prompt or slow pacing
    task automatic turn(input logic fwd, input int periods, input int gap);
        repeat (periods * 4) begin
            repeat (gap) @(posedge pclk);
            if (fwd ^ phase_a ^ phase_b) phase_a <= ~phase_a;
            else phase_b <= ~phase_b;
        end
    endtask
endmodule

//--- fbt_timer_tb.sv
// self-checking testbench of the base timer, driven over apb
`timescale 1ns/1ps
`include "fbt_consts.svh"
module fbt_timer_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pin_n = 1'b1;
    logic [7:0]  chan_event = 8'h00;
    logic [31:0] prdata, rd;
    logic        m_arm = 1'b0;
    logic        pready, pslverr, last_err, ph_a, ph_b, timer_irq, irq0, irq1, ch0_match;
    logic        saw_m = 1'b0;
    int          bad_count = 0;
    int          total_checks = 0;

    // ================================================================
    // clock, design and partner
    always #2.5 pclk = ~pclk;
    fbt_timer fbt_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phase_a_input(ph_a), .phase_b_input(ph_b),
        .external_reset_pin_n(pin_n), .chan_event(chan_event), .timer_irq(timer_irq),
        .shared_irq0(irq0), .shared_irq1(irq1), .ch0_match(ch0_match));
    fbt_phase_src fbt_phase_src_inst (.pclk(pclk), .phase_a(ph_a), .phase_b(ph_b));
    // match pulse lasts one cycle, so latch that it was seen once armed
    always @(posedge pclk) saw_m <= m_arm & (saw_m | (ch0_match === 1'b1));

    // ================================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer; waits for pready as long as it takes, watchdog bounds it
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // live count lies in a window, since reads take a few cycles themselves
    task automatic cnt_in(input string nm, input logic [31:0] lo, input logic [31:0] hi);
        apb(`FBT_OFF_COUNT, 1'b0, 32'h0);
        chk(nm, {31'h0, (rd >= lo && rd <= hi)}, 32'h1);
    endtask
    task automatic pulse(input logic [7:0] v);
        @(posedge pclk) chan_event <= v;
        @(posedge pclk) chan_event <= 8'h00;
        cyc(3);
    endtask

    // ================================================================
    // scenarios
    // all registers clear after reset, unmapped word refused
    task automatic t_reset;
        for (int a = 0; a <= 40; a += 4) begin
            apb(8'(a), 1'b0, 32'h0);
            chk("reset value", rd, `FBT_RD_ZERO);
        end
        apb(8'h2c, 1'b0, 32'h0);
        chk("unmapped err", {31'h0, last_err}, 32'h1);
    endtask
    // up mode: overflow select, wrap, stop and ignored writes
    task automatic t_count;
        wr(`FBT_OFF_CTRL0, 32'h08);
        wr(`FBT_OFF_CTRL1, 32'h01);
        wr(`FBT_OFF_COUNT, 32'h7ff0);
        cyc(30);
        chk("irq15 early", {31'h0, timer_irq}, 32'h0);
        cnt_in("live", 32'h8000, 32'h8040);
        wr(`FBT_OFF_COUNT, 32'hfff0);
        cyc(30);
        chk("irq15", {31'h0, timer_irq}, 32'h1);
        cnt_in("wrap", 32'h0, 32'h40);
        wr(`FBT_OFF_TIMER_IRQ, 32'h0);
        wr(`FBT_OFF_CTRL0, 32'h00);
        wr(`FBT_OFF_COUNT, 32'h7ff0);
        cyc(30);
        chk("irq14", {31'h0, timer_irq}, 32'h1);
        wr(`FBT_OFF_CTRL1, 32'h00);
        cnt_in("stopped", 32'h0, 32'h0);
        wr(`FBT_OFF_COUNT, 32'h1234);
        wr(`FBT_OFF_CTRL1, 32'h01);
        cnt_in("ignored", 32'h0, 32'h10);
        wr(`FBT_OFF_DIV, 32'h03);
        wr(`FBT_OFF_COUNT, 32'h0);
        cyc(40);
        cnt_in("divided", 32'h8, 32'hd);
        // f2 halves the rate again: one step every eight clocks
        wr(`FBT_OFF_CTRL0, 32'h01);
        wr(`FBT_OFF_COUNT, 32'h0);
        cyc(40);
        cnt_in("f2 divided", 32'h4, 32'h6);
        wr(`FBT_OFF_CTRL0, 32'h00);
        wr(`FBT_OFF_DIV, 32'h00);
    endtask
    // match resets: disabled, register match, channel 0 match
    task automatic t_match;
        wr(`FBT_OFF_MATCH, 32'h20);
        wr(`FBT_OFF_TIMER_IRQ, 32'h0);
        wr(`FBT_OFF_COUNT, 32'h0);
        cyc(60);
        cnt_in("match off", 32'h21, 32'h60);
        chk("irq off", {31'h0, timer_irq}, 32'h0);
        wr(`FBT_OFF_CH0CMP, 32'h10);
        wr(`FBT_OFF_CTRL0, 32'h04);
        wr(`FBT_OFF_COUNT, 32'h0);
        m_arm <= 1'b1;
        cyc(60);
        cnt_in("match on", 32'h0, 32'h20);
        chk("irq match", {31'h0, timer_irq}, 32'h1);
        chk("ch0 pulse", {31'h0, saw_m}, 32'h1);
        wr(`FBT_OFF_CTRL0, 32'h00);
        wr(`FBT_OFF_CH0CMP, 32'h18);
        wr(`FBT_OFF_CTRL1, 32'h03);
        wr(`FBT_OFF_COUNT, 32'h0);
        cyc(60);
        cnt_in("ch0 reset", 32'h0, 32'h18);
        wr(`FBT_OFF_CTRL1, 32'h05);
        @(posedge pclk) pin_n <= 1'b0;
        cyc(10);
        cnt_in("pin low", 32'h0, 32'h0);
        @(posedge pclk) pin_n <= 1'b1;
        cyc(10);
        cnt_in("pin high", 32'h1, 32'h20);
    endtask
    // up/down turns at both ends; two-phase counts pin edges both ways
    task automatic t_modes;
        wr(`FBT_OFF_CTRL1, 32'h11);
        wr(`FBT_OFF_COUNT, 32'hfff0);
        cyc(40);
        cnt_in("falling", 32'hffd0, 32'hffef);
        wr(`FBT_OFF_COUNT, 32'h0008);
        cyc(30);
        cnt_in("turn up", 32'hc, 32'h28);
        wr(`FBT_OFF_CTRL1, 32'h21);
        wr(`FBT_OFF_COUNT, 32'h0100);
        fbt_phase_src_inst.turn(1'b1, 3, 4);
        cyc(8);
        cnt_in("phase up", 32'h10c, 32'h10c);
        fbt_phase_src_inst.turn(1'b0, 1, 2);
        cyc(8);
        cnt_in("phase dn", 32'h108, 32'h108);
    endtask
    // channel requests, masks and the blocking of shared flags
    task automatic t_irq;
        wr(`FBT_OFF_MASK0, 32'h01);
        wr(`FBT_OFF_MASK1, 32'h02);
        pulse(8'h01);
        chk("irq0", {30'h0, irq1, irq0}, 32'h1);
        pulse(8'h02);
        chk("irq1", {30'h0, irq1, irq0}, 32'h3);
        wr(`FBT_OFF_SHARED, 32'h0);
        pulse(8'h01);
        chk("blocked", {30'h0, irq1, irq0}, 32'h0);
        apb(`FBT_OFF_CHREQ, 1'b0, 32'h0);
        chk("requests", rd, 32'h3);
        wr(`FBT_OFF_CHREQ, 32'h0);
        pulse(8'h04);
        chk("unmasked", {30'h0, irq1, irq0}, 32'h0);
        pulse(8'h01);
        chk("again", {30'h0, irq1, irq0}, 32'h1);
    endtask

    // ================================================================
    // verdict, main sequence and watchdog
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        cyc(10);
        presetn <= 1'b1;
        t_reset;
        t_count;
        t_match;
        t_modes;
        t_irq;
        tally_and_finish;
    end
    initial begin
        #100000;
        bad_count++;
        tally_and_finish;
    end
endmodule
